// ===== rtl/mfcb_defines.svh
// Purpose: offsets, field positions, reset values and timing counts of the feature control bits
// Assumes: AHB-Lite word registers, 10 MHz clock
// Notes: definitions only
`ifndef MFCB_DEFINES_SVH
`define MFCB_DEFINES_SVH

// register byte addresses
`define MFCB_ADDR_IMTX 12'h00C
`define MFCB_ADDR_TFC 12'h010
`define MFCB_ADDR_EVENT 12'h020
`define MFCB_ADDR_STATUS 12'h024
`define MFCB_ADDR_RESETREG 12'h028

// interrupt_mask_and_tx_control fields
`define MFCB_IMTX_TX_UNDERFLOW_ERROR_BIT 6
`define MFCB_IMTX_LAPP_BIT 5
`define MFCB_IMTX_T2PD_BIT 4
`define MFCB_IMTX_MODIFIED_BACKOFF_ENABLE_BIT 3
`define MFCB_IMTX_WMASK 16'h0078

// test_and_features_control fields
`define MFCB_TFC_TEST_BIT 15
`define MFCB_TFC_BURST_BIT 14
`define MFCB_TFC_TIMER_BIT 13
`define MFCB_TFC_POLL_BIT 12
`define MFCB_TFC_APAD_BIT 11
`define MFCB_TFC_STRP_BIT 10
`define MFCB_TFC_MISSED_COUNT_OVERFLOW_BIT 9
`define MFCB_TFC_MISSED_OVERFLOW_MASK_BIT 8

// event register bits (write one to pulse)
`define MFCB_EV_STOP_BIT 0
`define MFCB_EV_TX_DEMAND_BIT 1
`define MFCB_EV_TXSTART_BIT 2

// reset values
`define MFCB_IMTX_RESET 16'h0000
`define MFCB_TFC_RESET 16'h0100

// timing
`define MFCB_CLK_MHZ 10
`define MFCB_IDLE_NS 1000
`define MFCB_IDLE_CYC ((`MFCB_IDLE_NS * `MFCB_CLK_MHZ) / 1000)
`define MFCB_BAT_CYC 64
`define MFCB_POLL_CYC 200
`define MFCB_MIN_FRAME 64

`endif

// ===== rtl/mfcb_pkg.sv
// Purpose: types of the feature control bits block
// Assumes: nothing beyond the defines header
// Notes: types only
package mfcb_pkg;

   // state of the receive start-of-packet search
   typedef enum logic [2:0] {
      MFCB_RX_IDLE,
      MFCB_RX_FILL,
      MFCB_RX_SCAN,
      MFCB_RX_POLL,
      MFCB_RX_HOLD
   } mfcb_rx_st_t;

   // descriptor as seen by the receive search
   typedef struct packed {
      logic owned_by_device;
      logic start_of_packet_mark;
   } mfcb_desc_t;

   // control outputs toward the mac and buffer manager
   typedef struct packed {
      logic transmitter_on;
      logic two_part_defer_disable;
      logic modified_backoff_enable;
      logic test_mode_enable;
      logic burst_counter_enable;
      logic tx_auto_pad;
      logic tx_fcs_enable;
      logic rx_pad_strip;
      logic tx_poll_req;
      logic tx_ring_rescan;
      logic rx_interrupt_flag;
      logic summary_interrupt_flag;
      logic bus_hold;
      logic mixed_access_ok;
      logic desc_advance;
      logic desc_clear_own;
      logic desc_poll;
      logic desc_hold;
   } mfcb_ctl_t;

   // complete module state
   typedef struct packed {
      logic [15:0] imtx;
      logic [15:0] tfc;
      logic test_first_done;
      logic test_locked;
      mfcb_rx_st_t rx_st;
      logic [15:0] poll_cnt;
      logic [15:0] idle_cnt;
      logic [15:0] bat_cnt;
      logic [15:0] txpoll_cnt;
      mfcb_ctl_t ctl;
      logic hready;
      logic [31:0] hrdata;
      logic dp_wr;
      logic dp_rd;
      logic [11:0] dp_addr;
   } mfcb_state_t;

endpackage : mfcb_pkg

// ===== rtl/mfcb_regs.sv
// Purpose: control and status bits of the mac and buffer management unit
// Assumes: AHB-Lite single word transfers, 10 MHz hclk, event inputs on hclk
// Notes: descriptor and back-off engines live elsewhere; this block steers them
//
// Behaviour
// RULE1: underflow with recovery disabled turns the transmitter off.
// RULE2: underflow with recovery enabled rescans transmit ring for next frame.
// RULE3: recovery bit always accessible; cleared by reset or reset-register read.
// RULE4: lookahead raises receive interrupt after first descriptor write too.
// RULE5: lookahead starts each packet in a start-marked buffer.
// RULE6: after packet end, advance ignoring ownership; host entries untouched.
// RULE7: device-owned unmarked descriptors in search get ownership cleared.
// RULE8: start-marked host-owned descriptor stops search and is polled.
// RULE9: start-marked device-owned descriptor stops search, kept, waits frame.
// RULE10: lookahead bit always accessible, reset clears, stop ignores.
// RULE11: two-part deferral disable bit; reset clears, stop ignores.
// RULE12: bit 3 selects modified back-off; reset clears, stop ignores.
// RULE13: bit 15 test mode settable only on first write after reset.
// RULE14: bit 14 one disables burst counter; reset clears.
// RULE15: bit 13 allows mixed accesses; hold bus until timer or idle.
// RULE16: no request within 1 us after an operation releases the bus.
// RULE17: timer bit clear gives one access type per mastership.
// RULE18: bit 12 disables automatic transmit polling; none while transmitter off.
// RULE19: bit 11 pads transmit frames to 64 bytes, overrides fcs disable.
// RULE20: bit 10 strips receive pad and fcs; reset clears.
// RULE21: bit 9 set on counter overflow; write one, reset or stop clears.
// RULE22: bit 8 masks overflow flag from summary interrupt.
// RULE23: overflow mask set by reset, stop leaves it.
// RULE24: idle window counted in system clocks, restarted per bus operation.
`timescale 1ns/1ps
`default_nettype none
`include "mfcb_defines.svh"

module mfcb_regs (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic tx_underflow_error,
   input wire logic missed_count_overflow_evt,
   input wire logic tx_check_sequence_disable,
   input wire logic other_interrupt,
   input wire logic rx_first_desc_done,
   input wire logic rx_last_desc_done,
   input wire logic rx_desc_valid,
   input wire mfcb_pkg::mfcb_desc_t rx_desc,
   input wire logic rx_frame_arrive,
   input wire logic bus_op_done,
   input wire logic bus_op_req,
   output mfcb_pkg::mfcb_ctl_t ctl
);
   import mfcb_pkg::*;

   localparam logic [15:0] IDLE_CYC = 16'(`MFCB_IDLE_CYC);
   localparam logic [15:0] BAT_CYC = 16'(`MFCB_BAT_CYC);
   localparam logic [15:0] POLL_CYC = 16'(`MFCB_POLL_CYC);

   mfcb_state_t s_q;
   mfcb_state_t s_d;
   logic [15:0] wdata;
   logic write_en;
   logic stop_pulse;
   logic tx_demand_pulse;
   logic start_pulse;
   logic missed_count_overflow_clr;

   // write decode of the data phase
   assign wdata = hwdata[15:0];
   assign write_en = s_q.dp_wr;
   assign stop_pulse = write_en && s_q.dp_addr == `MFCB_ADDR_EVENT && hwdata[`MFCB_EV_STOP_BIT];
   assign tx_demand_pulse = write_en && s_q.dp_addr == `MFCB_ADDR_EVENT && hwdata[`MFCB_EV_TX_DEMAND_BIT];
   assign start_pulse = write_en && s_q.dp_addr == `MFCB_ADDR_EVENT && hwdata[`MFCB_EV_TXSTART_BIT];
   assign missed_count_overflow_clr = write_en && s_q.dp_addr == `MFCB_ADDR_TFC && wdata[`MFCB_TFC_MISSED_COUNT_OVERFLOW_BIT];

   // next state of every register, bus slave and engine
   always_comb begin
      s_d = s_q;
      s_d.hready = 1'b1;
      s_d.dp_wr = 1'b0;
      s_d.dp_rd = 1'b0;
      s_d.ctl.tx_poll_req = 1'b0;
      s_d.ctl.tx_ring_rescan = 1'b0;
      s_d.ctl.rx_interrupt_flag = 1'b0;
      s_d.ctl.desc_advance = 1'b0;
      s_d.ctl.desc_clear_own = 1'b0;
      s_d.ctl.desc_poll = 1'b0;

      // address phase capture; zero wait states
      if (hsel && hready && htrans[1]) begin
         s_d.dp_wr = hwrite;
         s_d.dp_rd = !hwrite;
         s_d.dp_addr = haddr;
      end

      // register writes; stop-insensitive bits keep their value
      if (write_en && s_q.dp_addr == `MFCB_ADDR_IMTX) begin
         // RULE3 always writable
         // RULE10 lookahead bit writable
         s_d.imtx = wdata & `MFCB_IMTX_WMASK;
      end
      if (write_en && s_q.dp_addr == `MFCB_ADDR_TFC) begin
         s_d.tfc[`MFCB_TFC_BURST_BIT:`MFCB_TFC_STRP_BIT] = wdata[`MFCB_TFC_BURST_BIT:`MFCB_TFC_STRP_BIT];
         s_d.tfc[`MFCB_TFC_MISSED_OVERFLOW_MASK_BIT] = wdata[`MFCB_TFC_MISSED_OVERFLOW_MASK_BIT];
         // RULE13 first write gate
         if (!wdata[`MFCB_TFC_TEST_BIT]) begin
            s_d.tfc[`MFCB_TFC_TEST_BIT] = 1'b0;
            s_d.test_locked = 1'b1;
         end else if (!s_q.test_first_done && !s_q.test_locked) begin
            s_d.tfc[`MFCB_TFC_TEST_BIT] = 1'b1;
         end
         s_d.test_first_done = 1'b1;
      end
      // RULE21 overflow flag, set wins over clear
      if (missed_count_overflow_clr || stop_pulse) begin
         s_d.tfc[`MFCB_TFC_MISSED_COUNT_OVERFLOW_BIT] = 1'b0;
      end
      if (missed_count_overflow_evt) begin
         s_d.tfc[`MFCB_TFC_MISSED_COUNT_OVERFLOW_BIT] = 1'b1;
      end

      // read data; reading the reset register clears the recovery bit
      if (s_q.dp_rd) begin
         s_d.hrdata = 32'h0000_0000;
      end
      if (hsel && hready && htrans[1] && !hwrite) begin
         unique case (haddr)
            `MFCB_ADDR_IMTX: s_d.hrdata = {16'h0000, s_d.imtx};
            `MFCB_ADDR_TFC: s_d.hrdata = {16'h0000, s_d.tfc};
            `MFCB_ADDR_STATUS: s_d.hrdata = {16'h0000, 11'h000, s_q.ctl.bus_hold,
               1'b0, s_q.rx_st};
            // RULE3 reset-register read
            `MFCB_ADDR_RESETREG: begin
               s_d.hrdata = 32'h0000_0000;
               s_d.imtx[`MFCB_IMTX_TX_UNDERFLOW_ERROR_BIT] = 1'b0;
            end
            default: s_d.hrdata = 32'h0000_0000;
         endcase
      end

      // transmitter on/off
      if (start_pulse) begin
         s_d.ctl.transmitter_on = 1'b1;
      end
      if (stop_pulse) begin
         s_d.ctl.transmitter_on = 1'b0;
      end
      if (tx_underflow_error && s_q.ctl.transmitter_on) begin
         if (!s_q.imtx[`MFCB_IMTX_TX_UNDERFLOW_ERROR_BIT]) begin
            // RULE1 stop transmitter
            s_d.ctl.transmitter_on = 1'b0;
         end else begin
            // RULE2 rescan ring
            s_d.ctl.tx_ring_rescan = 1'b1;
         end
      end

      // RULE18 transmit polling, host demand or periodic
      if (s_q.ctl.transmitter_on) begin
         if (s_q.tfc[`MFCB_TFC_POLL_BIT]) begin
            s_d.ctl.tx_poll_req = tx_demand_pulse;
            s_d.txpoll_cnt = 16'h0000;
         end else if (s_q.txpoll_cnt >= POLL_CYC - 16'h0001 || tx_demand_pulse) begin
            s_d.ctl.tx_poll_req = 1'b1;
            s_d.txpoll_cnt = 16'h0000;
         end else begin
            s_d.txpoll_cnt = s_q.txpoll_cnt + 16'h0001;
         end
      end else begin
         s_d.txpoll_cnt = 16'h0000;
      end

      // receive lookahead and start-of-packet search
      // RULE4 first descriptor interrupt
      s_d.ctl.rx_interrupt_flag = rx_last_desc_done || (s_q.imtx[`MFCB_IMTX_LAPP_BIT] && rx_first_desc_done);
      unique case (s_q.rx_st)
         MFCB_RX_IDLE, MFCB_RX_HOLD: begin
            // RULE9 wait for frame with stored descriptor
            if (rx_frame_arrive) begin
               s_d.rx_st = MFCB_RX_FILL;
               s_d.ctl.desc_hold = 1'b0;
            end
         end
         MFCB_RX_FILL: begin
            // RULE5 intermediate buffers need no mark
            if (rx_last_desc_done) begin
               s_d.rx_st = s_q.imtx[`MFCB_IMTX_LAPP_BIT] ? MFCB_RX_SCAN : MFCB_RX_IDLE;
               s_d.ctl.desc_advance = s_q.imtx[`MFCB_IMTX_LAPP_BIT];
            end
         end
         MFCB_RX_SCAN: begin
            if (rx_desc_valid) begin
               if (rx_desc.start_of_packet_mark && rx_desc.owned_by_device) begin
                  // RULE9 stop and keep
                  s_d.rx_st = MFCB_RX_HOLD;
                  s_d.ctl.desc_hold = 1'b1;
               end else if (rx_desc.start_of_packet_mark) begin
                  // RULE8 poll host-owned start
                  s_d.rx_st = MFCB_RX_POLL;
                  s_d.poll_cnt = 16'h0000;
               end else begin
                  // RULE6 advance regardless of owner
                  s_d.ctl.desc_advance = 1'b1;
                  // RULE7 clear device ownership
                  s_d.ctl.desc_clear_own = rx_desc.owned_by_device;
               end
            end
         end
         MFCB_RX_POLL: begin
            // RULE8 periodic re-read
            if (rx_desc_valid && rx_desc.owned_by_device) begin
               s_d.rx_st = MFCB_RX_HOLD;
               s_d.ctl.desc_hold = 1'b1;
            end else if (s_q.poll_cnt >= POLL_CYC - 16'h0001) begin
               s_d.ctl.desc_poll = 1'b1;
               s_d.poll_cnt = 16'h0000;
            end else begin
               s_d.poll_cnt = s_q.poll_cnt + 16'h0001;
            end
         end
      endcase

      // bus mastership hold
      // RULE15 mixed access under timer
      s_d.ctl.mixed_access_ok = s_q.tfc[`MFCB_TFC_TIMER_BIT];
      if (bus_op_req && !s_q.ctl.bus_hold) begin
         s_d.ctl.bus_hold = 1'b1;
         s_d.bat_cnt = 16'h0000;
         s_d.idle_cnt = 16'h0000;
      end else if (s_q.ctl.bus_hold) begin
         if (!s_q.tfc[`MFCB_TFC_TIMER_BIT]) begin
            // RULE17 single access type per mastership
            if (bus_op_done) begin
               s_d.ctl.bus_hold = 1'b0;
            end
         end else begin
            s_d.bat_cnt = s_q.bat_cnt + 16'h0001;
            // RULE24 idle window restarts per operation
            if (bus_op_done || bus_op_req) begin
               s_d.idle_cnt = 16'h0000;
            end else begin
               s_d.idle_cnt = s_q.idle_cnt + 16'h0001;
            end
            // RULE16 idle window release
            if (s_q.idle_cnt >= IDLE_CYC - 16'h0001 || s_q.bat_cnt >= BAT_CYC - 16'h0001) begin
               s_d.ctl.bus_hold = 1'b0;
            end
         end
      end

      // steering outputs
      // RULE11 deferral control
      s_d.ctl.two_part_defer_disable = s_d.imtx[`MFCB_IMTX_T2PD_BIT];
      // RULE12 back-off select
      s_d.ctl.modified_backoff_enable = s_d.imtx[`MFCB_IMTX_MODIFIED_BACKOFF_ENABLE_BIT];
      s_d.ctl.test_mode_enable = s_d.tfc[`MFCB_TFC_TEST_BIT];
      // RULE14 burst counter enable
      s_d.ctl.burst_counter_enable = !s_d.tfc[`MFCB_TFC_BURST_BIT];
      // RULE19 pad forces fcs on
      s_d.ctl.tx_auto_pad = s_d.tfc[`MFCB_TFC_APAD_BIT];
      s_d.ctl.tx_fcs_enable = s_d.tfc[`MFCB_TFC_APAD_BIT] || !tx_check_sequence_disable;
      // RULE20 strip control
      s_d.ctl.rx_pad_strip = s_d.tfc[`MFCB_TFC_STRP_BIT];
      // RULE22 mask gating
      s_d.ctl.summary_interrupt_flag = other_interrupt || s_d.ctl.rx_interrupt_flag ||
         (s_d.tfc[`MFCB_TFC_MISSED_COUNT_OVERFLOW_BIT] && !s_d.tfc[`MFCB_TFC_MISSED_OVERFLOW_MASK_BIT]);
   end

   // state register; RULE23 mask reset to one
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q <= '0;
         s_q.tfc <= `MFCB_TFC_RESET;
         s_q.imtx <= `MFCB_IMTX_RESET;
         s_q.hready <= 1'b1;
         s_q.ctl.burst_counter_enable <= 1'b1;
         s_q.ctl.tx_fcs_enable <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign hreadyout = s_q.hready;
   assign hrdata = s_q.hrdata;
   assign hresp = 1'b0;
   assign ctl = s_q.ctl;

endmodule : mfcb_regs
`default_nettype wire

// ===== tb/mfcb_regs_asserts.sv
// Purpose: port level checks of mfcb_regs
// Assumes: one hclk domain, zero wait state slave
// Notes: register bits are inferred from the bus writes seen at the ports
`timescale 1ns/1ps
`default_nettype none
`include "mfcb_defines.svh"
module mfcb_regs_asserts
   import mfcb_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   input wire logic tx_underflow_error,
   input wire logic rx_last_desc_done,
   input wire mfcb_pkg::mfcb_ctl_t ctl
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // write address phase, then its data phase; ctl shows it one edge later
   sequence s_take(logic [11:0] a);
      hsel && hready && htrans[1] && hwrite && haddr == a;
   endsequence
   sequence s_wr(logic [11:0] a);
      s_take(a) ##1 1'b1;
   endsequence

   property p_modified_backoff_enable;
      s_wr(`MFCB_ADDR_IMTX) |=> ctl.modified_backoff_enable == $past(hwdata[3]);
   endproperty
   a_modified_backoff_enable: assert property (p_modified_backoff_enable) else $error("back-off select not from write");
   property p_t2pd;
      s_wr(`MFCB_ADDR_IMTX) |=> ctl.two_part_defer_disable == $past(hwdata[4]);
   endproperty
   a_t2pd: assert property (p_t2pd) else $error("deferral disable not from write");
   property p_burst;
      s_wr(`MFCB_ADDR_TFC) |=> ctl.burst_counter_enable == !$past(hwdata[14]);
   endproperty
   a_burst: assert property (p_burst) else $error("burst counter enable wrong");
   property p_strip;
      s_wr(`MFCB_ADDR_TFC) |=> ctl.rx_pad_strip == $past(hwdata[10]);
   endproperty
   a_strip: assert property (p_strip) else $error("pad strip not from write");
   // underflow either rescans the ring or stops the transmitter
   property p_tx_underflow_error;
      tx_underflow_error |-> ##[1:2] (ctl.tx_ring_rescan || !ctl.transmitter_on);
   endproperty
   a_tx_underflow_error: assert property (p_tx_underflow_error) else $error("underflow left transmitter running");
   property p_lrint;
      rx_last_desc_done |-> ##[1:2] ctl.rx_interrupt_flag;
   endproperty
   a_lrint: assert property (p_lrint) else $error("no receive interrupt after last");
   property p_poll;
      !ctl.transmitter_on [*3] |-> !ctl.tx_poll_req;
   endproperty
   a_poll: assert property (p_poll) else $error("poll while transmitter off");
   // one cycle of slack covers the edge where auto pad itself rises
   property p_apad;
      ctl.tx_auto_pad && $past(ctl.tx_auto_pad) |-> ctl.tx_fcs_enable;
   endproperty
   a_apad: assert property (p_apad) else $error("auto pad did not force check sequence");
endmodule : mfcb_regs_asserts

bind mfcb_regs mfcb_regs_asserts mfcb_regs_asserts_inst (
   .hclk(hclk),
   .hresetn(hresetn),
   .hsel(hsel),
   .haddr(haddr),
   .htrans(htrans),
   .hwrite(hwrite),
   .hready(hready),
   .hwdata(hwdata),
   .tx_underflow_error(tx_underflow_error),
   .rx_last_desc_done(rx_last_desc_done),
   .ctl(ctl)
);
`default_nettype wire

// ===== tb/tb.sv
// Purpose: self-checking bench of mfcb_regs
// Assumes: zero wait state slave, events one cycle wide
// Notes: pulses on ctl are gathered over a few cycles, not timed exactly
`timescale 1ns/1ps
`default_nettype none
`include "mfcb_defines.svh"
module tb;
   import mfcb_pkg::*;
   localparam logic [11:0] im = `MFCB_ADDR_IMTX;
   localparam logic [11:0] tf = `MFCB_ADDR_TFC;
   localparam logic [11:0] evr = `MFCB_ADDR_EVENT;
   logic hclk = 1'h0;
   logic hresetn = 1'h0;
   logic hsel = 1'h0;
   logic [11:0] haddr = 12'h000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'h0;
   logic [31:0] hwdata = 32'h0;
   logic hreadyout;
   logic [31:0] hrdata;
   logic [6:0] ev = 7'h00;
   logic fcs_dis = 1'h0;
   logic breq = 1'h0;
   mfcb_desc_t rx_desc = '0;
   mfcb_ctl_t ctl;
   mfcb_ctl_t seen;
   logic [31:0] rd;
   int num_errors = 0;
   int num_checks = 0;
   int cyc = 0;

   mfcb_regs mfcb_regs_inst (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(),
      .tx_underflow_error(ev[0]), .missed_count_overflow_evt(ev[1]),
      .tx_check_sequence_disable(fcs_dis), .other_interrupt(1'h0),
      .rx_first_desc_done(ev[2]), .rx_last_desc_done(ev[3]), .rx_desc_valid(ev[6]),
      .rx_desc(rx_desc), .rx_frame_arrive(ev[4]), .bus_op_done(ev[5]),
      .bus_op_req(breq), .ctl(ctl)
   );

   // 100 ns clock
   always #50 hclk = ~hclk;

   // hang guard, well above the thousand or so cycles the run needs
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         results();
      end
   end

   task check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask : check

   // single word transfer; holds each phase until hready is seen high
   task xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'h1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'h1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'h1);
      rd = hrdata;
   endtask : xfer

   task wr(input logic [11:0] a, input logic [31:0] d);
      xfer(a, 1'h1, d);
   endtask : wr

   task rdc(input logic [11:0] a, input logic [31:0] e);
      xfer(a, 1'h0, 32'h0);
      check(rd, e);
   endtask : rdc

   // gather every ctl bit seen high over n cycles; the first look comes
   // right after the caller's edge so a one-cycle pulse launched there is seen
   task watch(input int n);
      seen = '0;
      repeat (n) begin
         #1;
         seen = mfcb_ctl_t'(seen | ctl);
         @(posedge hclk);
      end
   endtask : watch

   task pulse(input int i);
      @(posedge hclk);
      ev[i] <= 1'h1;
      @(posedge hclk);
      ev[i] <= 1'h0;
      watch(3);
   endtask : pulse

   task t_reset;
      rdc(im, 32'h0);
      rdc(tf, 32'h100);
      check({30'h0, ctl.burst_counter_enable, ctl.rx_pad_strip}, 32'h2);
      wr(12'h040, 32'hFFFF);
      rdc(12'h040, 32'h0);
      rdc(im, 32'h0);
   endtask : t_reset

   task t_imtx;
      wr(im, 32'hFFFF);
      rdc(im, 32'h78);
      check({30'h0, ctl.two_part_defer_disable, ctl.modified_backoff_enable}, 32'h3);
      wr(evr, 32'h1);
      rdc(im, 32'h78);
      xfer(`MFCB_ADDR_RESETREG, 1'h0, 32'h0);
      rdc(im, 32'h38);
      wr(im, 32'h0);
   endtask : t_imtx

   task t_tfc;
      wr(tf, 32'h8100);
      rdc(tf, 32'h8100);
      check({31'h0, ctl.test_mode_enable}, 32'h1);
      wr(tf, 32'h0100);
      wr(tf, 32'h8100);
      rdc(tf, 32'h0100);
      fcs_dis <= 1'h1;
      wr(tf, 32'h7D00);
      rdc(tf, 32'h7D00);
      check({28'h0, ctl.burst_counter_enable, ctl.tx_auto_pad, ctl.rx_pad_strip, ctl.tx_fcs_enable}, 32'h7);
      wr(tf, 32'h0100);
      watch(2);
      check({31'h0, ctl.tx_fcs_enable}, 32'h0);
      fcs_dis <= 1'h0;
   endtask : t_tfc

   task t_missed_count_overflow;
      pulse(1);
      rdc(tf, 32'h300);
      check({31'h0, ctl.summary_interrupt_flag}, 32'h0);
      wr(tf, 32'h0);
      watch(2);
      check({31'h0, ctl.summary_interrupt_flag}, 32'h1);
      rdc(tf, 32'h200);
      wr(tf, 32'h200);
      rdc(tf, 32'h0);
      pulse(1);
      wr(evr, 32'h1);
      rdc(tf, 32'h0);
      wr(tf, 32'h100);
   endtask : t_missed_count_overflow

   task t_tx;
      wr(evr, 32'h4);
      watch(2);
      check({31'h0, ctl.transmitter_on}, 32'h1);
      pulse(0);
      check({31'h0, ctl.transmitter_on}, 32'h0);
      wr(im, 32'h40);
      wr(evr, 32'h4);
      pulse(0);
      check({30'h0, seen.tx_ring_rescan, ctl.transmitter_on}, 32'h3);
      watch(250);
      check({31'h0, seen.tx_poll_req}, 32'h1);
      wr(tf, 32'h1100);
      // a poll launched on the write's own edge predates the disable
      @(posedge hclk);
      watch(250);
      check({31'h0, seen.tx_poll_req}, 32'h0);
      wr(evr, 32'h2);
      watch(2);
      check({31'h0, seen.tx_poll_req}, 32'h1);
      wr(tf, 32'h100);
   endtask : t_tx

   task t_lapp;
      pulse(2);
      check({31'h0, seen.rx_interrupt_flag}, 32'h0);
      wr(im, 32'h20);
      pulse(2);
      check({31'h0, seen.rx_interrupt_flag}, 32'h1);
      // a frame must arrive before its last descriptor starts the search
      pulse(4);
      pulse(3);
      check({31'h0, seen.desc_advance}, 32'h1);
      rx_desc <= '{1'h1, 1'h0};
      pulse(6);
      check({30'h0, seen.desc_advance, seen.desc_clear_own}, 32'h3);
      rx_desc <= '{1'h0, 1'h0};
      pulse(6);
      check({30'h0, seen.desc_advance, seen.desc_clear_own}, 32'h2);
      rx_desc <= '{1'h0, 1'h1};
      pulse(6);
      rdc(`MFCB_ADDR_STATUS, 32'h3);
      watch(210);
      check({31'h0, seen.desc_poll}, 32'h1);
      rx_desc <= '{1'h1, 1'h1};
      pulse(6);
      rdc(`MFCB_ADDR_STATUS, 32'h4);
      check({31'h0, ctl.desc_hold}, 32'h1);
   endtask : t_lapp

   // bus mastership: one operation without timer, idle window with it
   task t_bus;
      @(posedge hclk);
      breq <= 1'h1;
      @(posedge hclk);
      breq <= 1'h0;
      watch(1);
      check({31'h0, ctl.bus_hold}, 32'h1);
      pulse(5);
      check({31'h0, ctl.bus_hold}, 32'h0);
      wr(tf, 32'h2100);
      watch(2);
      check({31'h0, ctl.mixed_access_ok}, 32'h1);
      @(posedge hclk);
      breq <= 1'h1;
      @(posedge hclk);
      breq <= 1'h0;
      watch(5);
      pulse(5);
      watch(3);
      check({31'h0, ctl.bus_hold}, 32'h1);
      watch(8);
      check({31'h0, ctl.bus_hold}, 32'h0);
      wr(tf, 32'h100);
   endtask : t_bus

   task results;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : results

   // reset for 16 cycles, then the scenarios in turn
   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'h1;
      t_reset();
      t_imtx();
      t_tfc();
      t_missed_count_overflow();
      t_tx();
      t_lapp();
      t_bus();
      results();
   end
endmodule : tb
`default_nettype wire
